// ===== design/pbseq_top.sv
// push button power on/off sequencer: debounce, blanking, shutdown handshake, lockout
// assumes asynchronous pin inputs, 25 MHz clock, extension times given in whole ms
`default_nettype none
`include "pbseq_params.svh"

module pbseq_top
#(
    parameter bit          EN_ACTIVE_HIGH = 1'b1,                        // polarity variant
    parameter int unsigned DB_CYC    = `PBSEQ_CYC(`PBSEQ_DB_US),
    parameter int unsigned BLANK_CYC = `PBSEQ_CYC(`PBSEQ_BLANK_US),
    parameter int unsigned DOWN_CYC  = `PBSEQ_CYC(`PBSEQ_DOWN_US),
    parameter int unsigned LOCK_CYC  = `PBSEQ_CYC(`PBSEQ_LOCK_US),
    parameter int unsigned EXT_CYC   = `PBSEQ_CYC(`PBSEQ_EXT_BASE_US),
    parameter int unsigned REQ_CYC   = `PBSEQ_CYC(`PBSEQ_REQ_PW_US)
)
(
    input  wire logic        i_clk_sys,              // 25 MHz clock
    input  wire logic        i_rst_b,                // async reset, active low
    input  wire logic        i_push_button_n,        // button, low = pressed
    input  wire logic        i_power_off_req_n,      // host request, low = off
    input  wire logic [7:0]  i_on_delay_extension,   // extra on time, n+1 ms for n > 0, 0 = none
    input  wire logic [7:0]  i_off_delay_extension,  // extra off time, n+1 ms for n > 0, 0 = none
    output logic             o_power_en,             // power enable, polarity by parameter
    output logic             o_shutdown_int_n        // shutdown interrupt, active low
);

    // ==========================================================
    // state
    pbseq_pkg::pbseq_regs_type r_r;
    pbseq_pkg::pbseq_regs_type r_nxt;
    logic                      rst_int_b;
    logic [1:0]                rst_sync_r;

    assign rst_int_b = rst_sync_r[1];

    // ==========================================================
    // helpers
    function automatic logic [`PBSEQ_CNT_W-1:0] db_len(input logic [7:0] ext_ms);
        logic [`PBSEQ_CNT_W-1:0] v;
        v = `PBSEQ_CNT_W'(DB_CYC);
        if (ext_ms != 8'h00)
            v = v + `PBSEQ_CNT_W'(EXT_CYC) + `PBSEQ_CNT_W'(EXT_CYC * 32'(ext_ms));
        return v;
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.pb_sync  = {r_r.pb_sync[1:0], i_push_button_n};
        r_nxt.req_sync = {r_r.req_sync[1:0], i_power_off_req_n};
        // a change counts once the last two stages agree
        if (r_r.pb_sync[2] == r_r.pb_sync[1])
            r_nxt.pb_low = ~r_r.pb_sync[2];
        if (r_r.req_sync[2] == r_r.req_sync[1])
            r_nxt.req_low = ~r_r.req_sync[2];
        // short low pulses on the request line are glitches, not requests
        if (!r_r.req_low)
        begin
            r_nxt.req_cnt = 16'h0000;
            r_nxt.req_ok  = 1'b0;
        end
        else if (r_r.req_cnt >= 16'(REQ_CYC - 1))
            r_nxt.req_ok = 1'b1;
        else
            r_nxt.req_cnt = r_r.req_cnt + 16'h0001;

        r_nxt.cnt = r_r.cnt + `PBSEQ_CNT_W'(1);
        unique case (r_r.state)
            pbseq_pkg::PBSEQ_IDLE:
            begin
                r_nxt.cnt = '0;
                if (r_r.pb_low)
                    r_nxt.state = pbseq_pkg::PBSEQ_ON_DB;
            end
            pbseq_pkg::PBSEQ_ON_DB:
            begin
                if (!r_r.pb_low)
                    r_nxt.state = pbseq_pkg::PBSEQ_IDLE;
                else if (r_r.cnt >= db_len(i_on_delay_extension) - `PBSEQ_CNT_W'(1))
                begin
                    r_nxt.state = pbseq_pkg::PBSEQ_BLANK;
                    r_nxt.en    = 1'b1;
                    r_nxt.cnt   = '0;
                end
            end
            pbseq_pkg::PBSEQ_BLANK:
            begin
                // inputs are not looked at until the window closes
                if (r_r.cnt >= `PBSEQ_CNT_W'(BLANK_CYC - 1))
                begin
                    r_nxt.cnt = '0;
                    if (r_r.req_ok)
                    begin
                        r_nxt.en    = 1'b0;
                        r_nxt.state = pbseq_pkg::PBSEQ_LOCK;
                    end
                    else
                    begin
                        r_nxt.state = pbseq_pkg::PBSEQ_REL_DB;
                    end
                end
            end
            pbseq_pkg::PBSEQ_REL_DB, pbseq_pkg::PBSEQ_RUN, pbseq_pkg::PBSEQ_OFF_DB:
            begin
                if (r_r.req_ok)
                begin
                    r_nxt.en    = 1'b0;
                    r_nxt.state = pbseq_pkg::PBSEQ_LOCK;
                    r_nxt.cnt   = '0;
                end
                else if (r_r.state == pbseq_pkg::PBSEQ_REL_DB)
                begin
                    if (r_r.pb_low)
                        r_nxt.cnt = '0;
                    else if (r_r.cnt >= `PBSEQ_CNT_W'(DB_CYC - 1))
                    begin
                        r_nxt.state = pbseq_pkg::PBSEQ_RUN;
                        r_nxt.cnt   = '0;
                    end
                end
                else if (r_r.state == pbseq_pkg::PBSEQ_RUN)
                begin
                    r_nxt.cnt = '0;
                    if (r_r.pb_low)
                        r_nxt.state = pbseq_pkg::PBSEQ_OFF_DB;
                end
                else if (!r_r.pb_low)
                    r_nxt.state = pbseq_pkg::PBSEQ_RUN;
                else if (r_r.cnt >= db_len(i_off_delay_extension) - `PBSEQ_CNT_W'(1))
                begin
                    r_nxt.state  = pbseq_pkg::PBSEQ_DOWN;
                    r_nxt.shut_n = 1'b0;
                    r_nxt.cnt    = '0;
                end
            end
            pbseq_pkg::PBSEQ_DOWN:
            begin
                if (r_r.req_ok || r_r.cnt >= `PBSEQ_CNT_W'(DOWN_CYC - 1))
                begin
                    r_nxt.en    = 1'b0;
                    r_nxt.state = pbseq_pkg::PBSEQ_LOCK;
                    r_nxt.cnt   = '0;
                end
            end
            pbseq_pkg::PBSEQ_LOCK:
            begin
                // a held button pulls the count back, so idle needs a full
                // release debounce after the last low; lockout must exceed it
                if (r_r.pb_low && r_r.cnt > `PBSEQ_CNT_W'(LOCK_CYC - DB_CYC - 1))
                    r_nxt.cnt = `PBSEQ_CNT_W'(LOCK_CYC - DB_CYC - 1);
                else if (r_r.cnt >= `PBSEQ_CNT_W'(LOCK_CYC - 1))
                begin
                    r_nxt.cnt = r_r.cnt;
                    if (!r_r.pb_low)
                        r_nxt.state = pbseq_pkg::PBSEQ_IDLE;
                end
            end
        endcase
        if (r_r.state == pbseq_pkg::PBSEQ_LOCK || !r_nxt.en)
            r_nxt.shut_n = 1'b1;
        if (r_r.state == pbseq_pkg::PBSEQ_DOWN && r_nxt.en)
            r_nxt.shut_n = 1'b0;
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    always_ff @(posedge i_clk_sys or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            r_r.pb_sync  <= 3'h7;
            r_r.req_sync <= 3'h7;
            r_r.pb_low   <= 1'b0;
            r_r.req_low  <= 1'b0;
            r_r.req_cnt  <= 16'h0000;
            r_r.req_ok   <= 1'b0;
            r_r.state    <= pbseq_pkg::PBSEQ_IDLE;
            r_r.cnt      <= '0;
            r_r.en       <= 1'b0;
            r_r.shut_n   <= 1'b1;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // output flops; polarity applied on the flop input so outputs stay registered
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_power_en       <= ~EN_ACTIVE_HIGH;
            o_shutdown_int_n <= 1'b1;
        end
        else
        begin
            o_power_en       <= (r_r.en & rst_int_b) ~^ EN_ACTIVE_HIGH;
            o_shutdown_int_n <= r_r.shut_n | ~rst_int_b;
        end
    end

endmodule

`default_nettype wire

// ===== shared/pbseq_params.svh
// timing constants of the push button power sequencer
// assumes a 25 MHz system clock; times are in microseconds
`ifndef PBSEQ_PARAMS_SVH
`define PBSEQ_PARAMS_SVH

`define PBSEQ_CLK_KHZ        25000
`define PBSEQ_DB_US          32000
`define PBSEQ_EXT_BASE_US    1000
`define PBSEQ_BLANK_US       512000
`define PBSEQ_DOWN_US        1024000
`define PBSEQ_LOCK_US        256000
`define PBSEQ_REQ_PW_US      30
// scaled per us first so the long timers stay inside 32-bit arithmetic;
// limitation: the clock must be a whole number of MHz
`define PBSEQ_CYC(us)        ((us) * (`PBSEQ_CLK_KHZ / 1000))
`define PBSEQ_CNT_W          25

`endif

// ===== shared/pbseq_pkg.sv
// types of the push button power sequencer
// assumes pbseq_params.svh for the counter width
`default_nettype none
`include "pbseq_params.svh"

package pbseq_pkg;

    typedef enum logic [2:0]
    {
        PBSEQ_IDLE,
        PBSEQ_ON_DB,
        PBSEQ_BLANK,
        PBSEQ_REL_DB,
        PBSEQ_RUN,
        PBSEQ_OFF_DB,
        PBSEQ_DOWN,
        PBSEQ_LOCK
    } pbseq_state_type;

    typedef struct packed
    {
        logic [2:0]               pb_sync;
        logic [2:0]               req_sync;
        logic                     pb_low;
        logic                     req_low;
        logic [15:0]              req_cnt;
        logic                     req_ok;
        pbseq_state_type          state;
        logic [`PBSEQ_CNT_W-1:0]  cnt;
        logic                     en;
        logic                     shut_n;
    } pbseq_regs_type;

endpackage

`default_nettype wire

// ===== test/pbseq_host_model.sv
// host processor model driving the power-off request line
// assumes i_en_on is high while the host has power
`default_nettype none
module pbseq_host_model
(
    input  wire logic       i_clk,    // system clock
    input  wire logic       i_en_on,  // host powered
    input  wire logic       i_int_n,  // shutdown interrupt
    input  wire logic       i_kill,   // bench-forced request
    input  wire logic [1:0] i_mode,   // 0 ack, 1 never rise, 2 ignore int
    output logic            o_req_n   // power-off request
);
    timeunit 1ns;
    timeprecision 1ns;
    int age = 0;
    int ack = 0;
    always @(posedge i_clk)
    begin
        age <= i_en_on ? age + 1 : 0;
        ack <= (i_en_on && !i_int_n && i_mode == 2'h0) ? ack + 1 : 0;
    end
    // unpowered host holds the line low, so blanking must cover boot time
    assign o_req_n = i_en_on && age > 12 && i_mode != 2'h1 && ack < 20 && !i_kill;
endmodule
`default_nettype wire

// ===== test/pbseq_top_assertions.sv
// timing checks of the sequencer outputs against its inputs
// assumes bind to pbseq_top with matching parameters
`default_nettype none
module pbseq_chk
#(
    parameter bit          EN_ACTIVE_HIGH = 1'b1,
    parameter int unsigned DB_CYC         = 20,
    parameter int unsigned BLANK_CYC      = 80,
    parameter int unsigned DOWN_CYC       = 160,
    parameter int unsigned LOCK_CYC       = 40,
    parameter int unsigned REQ_CYC        = 3
)
(
    input wire logic i_clk_sys,         // clock
    input wire logic i_rst_b,           // reset, active low
    input wire logic i_push_button_n,   // button
    input wire logic i_power_off_req_n, // host request
    input wire logic o_power_en,        // enable
    input wire logic o_shutdown_int_n   // interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DWN_MAX = DOWN_CYC + 12;
    localparam int REQ_MAX = REQ_CYC + 10;
    logic        on_w;
    logic [15:0] low_c;
    logic [15:0] run_c;
    logic [15:0] off_c;
    logic [15:0] dn_c;
    logic [15:0] hi_c;
    assign on_w = (o_power_en == EN_ACTIVE_HIGH);
    // ==========================================
    // saturating span counters
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            low_c <= 16'h0;
            run_c <= 16'h0;
            off_c <= 16'hFFFF;
            dn_c  <= 16'h0;
            hi_c  <= 16'h0;
        end
        else
        begin
            low_c <= i_push_button_n ? 16'h0 : low_c + {15'h0, ~&low_c};
            run_c <= on_w ? run_c + {15'h0, ~&run_c} : 16'h0;
            off_c <= on_w ? 16'h0 : off_c + {15'h0, ~&off_c};
            dn_c  <= o_shutdown_int_n ? 16'h0 : dn_c + {15'h0, ~&dn_c};
            hi_c  <= i_power_off_req_n ? hi_c + {15'h0, ~&hi_c} : 16'h0;
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    AST_OFF_AT_RESET: assert property ($rose(i_rst_b) |-> !on_w) else $error("enable on at reset");
    AST_ON_DEBOUNCE: assert property ($rose(on_w) |-> low_c >= DB_CYC) else $error("early turn-on");
    AST_BLANK_HOLD: assert property ($rose(on_w) |-> on_w[*8]) else $error("off inside blanking");
    AST_BLANK_MIN: assert property ($fell(on_w) |-> run_c >= BLANK_CYC - 1) else $error("short blanking");
    AST_OFF_DEBOUNCE: assert property ($fell(o_shutdown_int_n) |-> low_c >= DB_CYC) else $error("early int");
    AST_INT_WHILE_ON: assert property (!o_shutdown_int_n |-> on_w) else $error("int low while off");
    AST_INT_AT_OFF: assert property ($fell(on_w) |-> o_shutdown_int_n) else $error("int low at release");
    AST_DOWN_LIMIT: assert property ($fell(o_shutdown_int_n) |-> ##[1:DWN_MAX] !on_w) else $error("no timeout");
    AST_DOWN_FULL: assert property ($rose(o_shutdown_int_n) && hi_c > REQ_MAX |-> dn_c >= DOWN_CYC - 1)
        else $error("power-down cut short");
    AST_REQ_IN_DOWN: assert property ((!o_shutdown_int_n && !i_power_off_req_n)[*6] |-> ##[0:REQ_MAX] !on_w)
        else $error("request ignored in power-down");
    AST_REQ_IN_RUN: assert property ((on_w && run_c > BLANK_CYC + 8 && !i_power_off_req_n)[*6]
        |-> ##[0:REQ_MAX] !on_w) else $error("request ignored in run");
    AST_LOCKOUT: assert property ($rose(on_w) |-> off_c >= LOCK_CYC) else $error("turn-on in lockout");
endmodule
bind pbseq_top pbseq_chk #(.EN_ACTIVE_HIGH(EN_ACTIVE_HIGH), .DB_CYC(DB_CYC), .BLANK_CYC(BLANK_CYC),
    .DOWN_CYC(DOWN_CYC), .LOCK_CYC(LOCK_CYC), .REQ_CYC(REQ_CYC)) pbseq_chk_inst (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_push_button_n(i_push_button_n), .i_power_off_req_n(i_power_off_req_n),
    .o_power_en(o_power_en), .o_shutdown_int_n(o_shutdown_int_n));
`default_nettype wire

// ===== test/tb_top.sv
// testbench: button presses and host replies, output changes checked in order
// assumes shortened timer parameters and the inverted enable variant
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam bit POL = 1'b0;
    localparam int DB = 20, BL = 80, DN = 160, LK = 40, EX = 4, RQ = 3;
    localparam logic [1:0] ON = {POL, 1'b1}, OFF = {~POL, 1'b1}, DWN = {POL, 1'b0};
    logic       clk, rst_b, btn, kill, pen, sint_n, req_n;
    logic [1:0] mode, last;
    logic [7:0] eon, eoff;
    logic [1:0] q[$];
    int         n_mismatch = 0, checks_done = 0;
    pbseq_top #(.EN_ACTIVE_HIGH(POL), .DB_CYC(DB), .BLANK_CYC(BL), .DOWN_CYC(DN), .LOCK_CYC(LK), .EXT_CYC(EX),
        .REQ_CYC(RQ)) pbseq_top_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_push_button_n(btn),
        .i_power_off_req_n(req_n), .i_on_delay_extension(eon), .i_off_delay_extension(eoff),
        .o_power_en(pen), .o_shutdown_int_n(sint_n));
    pbseq_host_model pbseq_host_model_inst (.i_clk(clk), .i_en_on(pen == POL), .i_int_n(sint_n),
        .i_kill(kill), .i_mode(mode), .o_req_n(req_n));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input string nm, input logic [1:0] s, input logic [1:0] x);
        checks_done++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %b seen %b", nm, x, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task press(input int n);
        btn = 1'b0;
        cyc(n);
        btn = 1'b1;
    endtask
    // ==========================================
    // every output change must match the oldest note
    always @(negedge clk)
    begin
        if (rst_b && {pen, sint_n} !== last)
        begin
            if (q.size() == 0)
                chk("spurious change", {pen, sint_n}, last);
            else
                chk("outputs", {pen, sint_n}, q.pop_front());
            last = {pen, sint_n};
        end
    end
    initial
    begin
        #(40 * 5000);
        n_mismatch++;
        final_report;
    end
    // ==========================================
    // scenarios
    initial
    begin
        {rst_b, kill, mode, eon, eoff} = '0;
        btn = 1'b1;
        last = OFF;
        void'($urandom(20));
        cyc(16);
        rst_b = 1'b1;
        cyc(4);
        chk("reset", {pen, sint_n}, OFF);
        repeat (3)
        begin
            press($urandom_range(2, DB - 4));
            cyc(6);
        end
        chk("bounce", {pen, sint_n}, OFF);
        q.push_back(ON);
        press(DB + 30);
        cyc(BL + DB + 20);
        q.push_back(DWN);
        q.push_back(OFF);
        press(DB + 10);
        cyc(30);
        press(25); // lands inside lockout
        cyc(LK + DB + 20);
        mode = 2'h2;
        eon = 8'h2;
        eoff = 8'($urandom_range(1, 3));
        press(DB + EX * 3 - 6);
        cyc(10);
        chk("extended on", {pen, sint_n}, OFF);
        q.push_back(ON);
        press(DB + EX * 3 + 10);
        cyc(BL + DB + 20);
        q.push_back(DWN);
        q.push_back(OFF);
        press(DB + EX * (eoff + 1) + 10);
        cyc(DN + LK + DB + 40);
        mode = 2'h1;
        {eon, eoff} = '0;
        q.push_back(ON);
        q.push_back(OFF);
        press(DB + 10);
        cyc(BL + LK + DB + 30);
        mode = 2'h0;
        q.push_back(ON);
        press(DB + 10);
        cyc(BL + DB + 20);
        kill = 1'b1;
        cyc(1);
        kill = 1'b0;
        cyc(20);
        chk("glitch", {pen, sint_n}, ON);
        q.push_back(OFF);
        kill = 1'b1;
        cyc(10);
        kill = 1'b0;
        cyc(LK);
        chk("notes left", 2'(q.size()), 2'h0);
        final_report;
    end
endmodule
`default_nettype wire
